/* File: design/pmwd_ctrl.sv */
// power mode wake and doze controller with its apb register file
`timescale 1ns/1ns
`default_nettype none
module pmwd_ctrl
  import pmwd_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic                      pready,
  output logic                      pslverr,
  output logic [31:0]               prdata,
  input  wire logic                 psave_valid,
  input  wire logic                 psave_idle,
  input  wire logic [PRIO_W-1:0]    cpu_priority,
  input  wire logic                 irq_pending,
  input  wire logic                 irq_enabled,
  input  wire logic [PRIO_W-1:0]    irq_priority,
  input  wire logic                 wdt_expire,
  input  wire logic                 soft_reset_req,
  input  wire logic [OSC_SEL_W-1:0] osc_source,
  output logic                      cpu_clk_en,
  output logic                      cpu_halted,
  output logic                      periph_clk_en,
  output logic                      sys_osc_en,
  output logic                      low_power_rc_oscillator_en,
  output logic [OSC_SEL_W-1:0]      active_osc,
  output logic                      wdt_clear,
  output logic                      wake_resume,
  output logic                      wake_isr,
  output logic                      cpu_reset,
  output logic                      doze_active
);

  typedef struct packed {
    pmwd_mode_t            mode;
    logic                  enter_idle;
    logic                  watchdog_timeout_flag;
    logic                  was_asleep;
    logic                  was_idle;
    logic                  return_on_interrupt;
    logic [2:0]            ratio;
    logic                  doze_en;
    logic [2:0]            rcdiv;
    logic                  wdt_en;
    logic                  fail_safe_clock_monitor_en;
    logic [OSC_SEL_W-1:0]  osc;
    logic                  wdt_clear;
    logic                  wake_resume;
    logic                  wake_isr;
    logic                  cpu_reset;
    logic [31:0]           rdata;
  } pmwd_state_t;

  pmwd_state_t q;
  pmwd_state_t d;

  pmwd_doze_if dz ();

  logic apb_setup;
  logic apb_wr;
  logic addr_ok;
  logic irq_wake;
  logic irq_to_isr;
  logic halted;

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = (a == ADDR_RESET_CTRL) || (a == ADDR_CLOCK_DIV) ||
                  (a == ADDR_CONFIG) || (a == ADDR_STATUS);
  endfunction

  function automatic logic [31:0] read_mux(input pmwd_state_t s,
                                           input logic [ADDR_W-1:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      ADDR_RESET_CTRL: begin
        r[RC_WATCHDOG_TIMEOUT_FLAG_BIT]   = s.watchdog_timeout_flag;
        r[RC_ASLEEP_BIT] = s.was_asleep;
        r[RC_IDLE_BIT]   = s.was_idle;
      end
      ADDR_CLOCK_DIV: begin
        r[CD_ROI_BIT]                     = s.return_on_interrupt;
        r[CD_RATIO_LSB +: 3]              = s.ratio;
        r[CD_DOZE_BIT]                    = s.doze_en;
        r[CD_RCDIV_LSB +: 3]              = s.rcdiv;
      end
      ADDR_CONFIG: begin
        r[CFG_WDT_EN_BIT]  = s.wdt_en;
        r[CFG_FAIL_SAFE_CLOCK_MONITOR_EN_BIT] = s.fail_safe_clock_monitor_en;
      end
      ADDR_STATUS: begin
        r[ST_MODE_LSB +: 2] = s.mode;
        r[ST_DOZE_BIT]      = s.doze_en;
      end
      default: begin
        r = 32'h0000_0000;
      end
    endcase
    read_mux = r;
  endfunction

  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite && addr_ok;
  assign addr_ok   = addr_mapped(paddr);

  // level-0 sources count as disabled
  assign irq_wake   = irq_pending && irq_enabled && (irq_priority != 3'h0);
  assign irq_to_isr = irq_priority > cpu_priority;

  always_comb begin
    d             = q;
    d.wdt_clear   = 1'b0;
    d.wake_resume = 1'b0;
    d.wake_isr    = 1'b0;
    d.cpu_reset   = 1'b0;
    if (apb_setup) begin
      d.rdata = read_mux(q, paddr);
    end
    // software writes first, hardware sets below win
    if (apb_wr && pstrb[0]) begin
      case (paddr)
        ADDR_RESET_CTRL: begin
          d.watchdog_timeout_flag       = pwdata[RC_WATCHDOG_TIMEOUT_FLAG_BIT];
          d.was_asleep = pwdata[RC_ASLEEP_BIT];
          d.was_idle   = pwdata[RC_IDLE_BIT];
        end
        ADDR_CONFIG: begin
          d.wdt_en  = pwdata[CFG_WDT_EN_BIT];
          d.fail_safe_clock_monitor_en = pwdata[CFG_FAIL_SAFE_CLOCK_MONITOR_EN_BIT];
        end
        default: begin
        end
      endcase
    end
    if (apb_wr && pstrb[1] && (paddr == ADDR_CLOCK_DIV)) begin
      d.return_on_interrupt     = pwdata[CD_ROI_BIT];
      d.ratio   = pwdata[CD_RATIO_LSB +: 3];
      d.doze_en = pwdata[CD_DOZE_BIT];
      d.rcdiv   = pwdata[CD_RCDIV_LSB +: 3];
    end
    // return to full speed on interrupt only when enabled
    if ((q.mode == PMWD_RUN) && q.doze_en && q.return_on_interrupt && irq_wake) begin
      d.doze_en = 1'b0;
    end
    case (q.mode)
      PMWD_RUN: begin
        d.osc = osc_source;
        if (psave_valid) begin
          d.mode       = PMWD_ENTER;
          d.enter_idle = psave_idle;
        end
      end
      PMWD_ENTER: begin
        // interrupts are held off in this cycle
        d.mode      = q.enter_idle ? PMWD_IDLE : PMWD_SLEEP;
        d.wdt_clear = q.enter_idle || q.wdt_en;
      end
      PMWD_SLEEP: begin
        if (q.wdt_en && wdt_expire) begin
          d.watchdog_timeout_flag        = 1'b1;
          d.was_asleep  = 1'b1;
          d.wake_resume = 1'b1;
          d.mode        = PMWD_RUN;
        end else if (irq_wake) begin
          d.was_asleep  = 1'b1;
          d.wake_isr    = irq_to_isr;
          d.wake_resume = !irq_to_isr;
          d.mode        = PMWD_RUN;
        end
      end
      PMWD_IDLE: begin
        if (q.wdt_en && wdt_expire) begin
          d.watchdog_timeout_flag        = 1'b1;
          d.was_idle    = 1'b1;
          d.wake_resume = 1'b1;
          d.mode        = PMWD_RUN;
        end else if (irq_wake) begin
          d.was_idle    = 1'b1;
          d.wake_isr    = irq_to_isr;
          d.wake_resume = !irq_to_isr;
          d.mode        = PMWD_RUN;
        end
      end
      default: begin
        d.mode = PMWD_RUN;
      end
    endcase
    // non power-on reset wakes from any low-power mode
    if (soft_reset_req) begin
      d.wake_resume = 1'b0;
      d.wake_isr    = 1'b0;
      d.cpu_reset   = 1'b1;
      d.mode        = PMWD_RUN;
      if ((q.mode == PMWD_SLEEP) || ((q.mode == PMWD_ENTER) && !q.enter_idle)) begin
        d.was_asleep = 1'b1;
      end
      if ((q.mode == PMWD_IDLE) || ((q.mode == PMWD_ENTER) && q.enter_idle)) begin
        d.was_idle = 1'b1;
      end
    end
  end

  // power-on reset clears the mode flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{mode:        PMWD_RUN,
             enter_idle:  1'b0,
             watchdog_timeout_flag:        1'b0,
             was_asleep:  1'b0,
             was_idle:    1'b0,
             return_on_interrupt:         1'b0,
             ratio:       CD_RATIO_RESET,
             doze_en:     1'b0,
             rcdiv:       CD_RCDIV_RESET,
             wdt_en:      1'b0,
             fail_safe_clock_monitor_en:     1'b0,
             osc:         '0,
             wdt_clear:   1'b0,
             wake_resume: 1'b0,
             wake_isr:    1'b0,
             cpu_reset:   1'b0,
             rdata:       32'h0000_0000};
    end else begin
      q <= d;
    end
  end

  assign dz.enable = q.doze_en;
  assign dz.ratio  = q.ratio;

  pmwd_doze_div u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .dz      (dz)
  );

  assign halted        = (q.mode != PMWD_RUN);
  assign cpu_halted    = halted;
  assign cpu_clk_en    = !halted && dz.tick;
  assign periph_clk_en = (q.mode != PMWD_SLEEP);
  assign sys_osc_en    = (q.mode != PMWD_SLEEP);
  assign low_power_rc_oscillator_en       = q.wdt_en || ((q.mode != PMWD_SLEEP) && q.fail_safe_clock_monitor_en);
  assign active_osc    = q.osc;
  assign wdt_clear     = q.wdt_clear;
  assign wake_resume   = q.wake_resume;
  assign wake_isr      = q.wake_isr;
  assign cpu_reset     = q.cpu_reset;
  assign doze_active   = q.doze_en;
  assign pready        = 1'b1;
  assign pslverr       = psel && penable && !addr_ok;
  assign prdata        = q.rdata;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_sleep_prio_zero: assert property (
    (q.mode == PMWD_SLEEP) && irq_pending && (irq_priority == 3'h0) &&
    !(q.wdt_en && wdt_expire) && !soft_reset_req |=> (q.mode == PMWD_SLEEP))
    else $error("level 0 interrupt woke sleep");

  chk_wake_to_handler: assert property (
    ((q.mode == PMWD_SLEEP) || (q.mode == PMWD_IDLE)) && irq_wake &&
    !(q.wdt_en && wdt_expire) && !soft_reset_req
    |=> (wake_isr == $past(irq_to_isr)) && (wake_resume != wake_isr) && !halted)
    else $error("wake target wrong");

  chk_sleep_wake_flag: assert property (
    (q.mode == PMWD_SLEEP) ##1 (q.mode == PMWD_RUN) |-> q.was_asleep)
    else $error("was-asleep not set on wake");

  chk_reset_wakes_sleep: assert property (
    (q.mode == PMWD_SLEEP) && soft_reset_req
    |=> cpu_reset && q.was_asleep && (q.mode == PMWD_RUN) ##1 !cpu_reset)
    else $error("reset did not wake sleep");

  chk_wdt_in_sleep: assert property (
    (q.mode == PMWD_SLEEP) && q.wdt_en && wdt_expire && !soft_reset_req
    |=> q.watchdog_timeout_flag && q.was_asleep && wake_resume && !cpu_reset && !wake_isr)
    else $error("watchdog wake from sleep wrong");

  chk_idle_entry: assert property (
    (q.mode == PMWD_ENTER) && q.enter_idle && !soft_reset_req
    |=> (q.mode == PMWD_IDLE) && wdt_clear && !cpu_clk_en && periph_clk_en && sys_osc_en)
    else $error("idle entry wrong");

  chk_idle_low_power_rc_oscillator: assert property (
    (q.mode == PMWD_IDLE) && (q.wdt_en || q.fail_safe_clock_monitor_en) |-> low_power_rc_oscillator_en)
    else $error("rc oscillator off in idle");

  chk_idle_wake_now: assert property (
    (q.mode == PMWD_IDLE) && irq_wake |=> (q.mode == PMWD_RUN) && q.was_idle)
    else $error("idle wake delayed");

  chk_wdt_in_idle: assert property (
    (q.mode == PMWD_IDLE) && q.wdt_en && wdt_expire && !soft_reset_req
    |=> q.watchdog_timeout_flag && q.was_idle && wake_resume && !cpu_reset)
    else $error("watchdog wake from idle wrong");

  chk_defer_entry: assert property (
    (q.mode == PMWD_RUN) && psave_valid && !soft_reset_req
    |=> (q.mode == PMWD_ENTER) ##1 ((q.mode == PMWD_SLEEP) || (q.mode == PMWD_IDLE) ||
    $past(soft_reset_req)))
    else $error("power-save entry not completed");

  chk_doze_roi_clear: assert property (
    (q.mode == PMWD_RUN) && q.doze_en && q.return_on_interrupt && irq_wake && !apb_wr |=> !q.doze_en)
    else $error("doze not cleared on interrupt");

  chk_doze_roi_off: assert property (
    (q.mode == PMWD_RUN) && q.doze_en && !q.return_on_interrupt && !apb_wr |=> q.doze_en)
    else $error("doze changed without return-on-interrupt");

  chk_sleep_clocks: assert property (
    (q.mode == PMWD_SLEEP) |-> !sys_osc_en && !periph_clk_en && !cpu_clk_en &&
    $stable(active_osc))
    else $error("clocks running in sleep");

  chk_idle_prio_zero: assert property (
    (q.mode == PMWD_IDLE) && irq_pending && (irq_priority == 3'h0) &&
    !(q.wdt_en && wdt_expire) && !soft_reset_req |=> (q.mode == PMWD_IDLE))
    else $error("level 0 interrupt woke idle");

  chk_idle_wake_flag: assert property (
    (q.mode == PMWD_IDLE) ##1 (q.mode == PMWD_RUN) |-> q.was_idle)
    else $error("was-idle not set on wake");

  chk_sleep_wdt_clear: assert property (
    (q.mode == PMWD_ENTER) && !q.enter_idle && q.wdt_en && !soft_reset_req
    |=> (q.mode == PMWD_SLEEP) && wdt_clear)
    else $error("watchdog not cleared at sleep entry");

  cov_sleep_isr: cover property (
    (q.mode == PMWD_SLEEP) ##1 wake_isr);
  cov_idle_wdt: cover property (
    (q.mode == PMWD_IDLE) ##1 (wake_resume && q.watchdog_timeout_flag));
  cov_doze_return: cover property (
    q.doze_en && q.return_on_interrupt ##1 !q.doze_en);
  cov_reset_idle: cover property (
    (q.mode == PMWD_IDLE) ##1 cpu_reset);

endmodule
`default_nettype wire

/* File: design/pmwd_doze_div.sv */
// core clock enable divider for doze operation
`timescale 1ns/1ns
`default_nettype none
module pmwd_doze_div
  import pmwd_pkg::*;
(
  input  wire logic      pclk,
  input  wire logic      presetn,
  pmwd_doze_if.div       dz
);

  typedef struct packed {
    logic [DOZE_CNT_W-1:0] cnt;
    logic                  tick;
  } pmwd_div_state_t;

  pmwd_div_state_t q;
  pmwd_div_state_t d;

  // low bits that must wrap before the next core tick
  function automatic logic [DOZE_CNT_W-1:0] ratio_mask(input logic [2:0] n);
    ratio_mask = DOZE_CNT_W'((8'h01 << n) - 8'h01);
  endfunction

  always_comb begin
    d = q;
    if (!dz.enable) begin
      d.cnt  = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt  = q.cnt + 7'h01;
      d.tick = ((d.cnt & ratio_mask(dz.ratio)) == '0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{cnt: '0, tick: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign dz.tick = q.tick;

endmodule
`default_nettype wire

/* File: design/pmwd_doze_if.sv */
// carrier between the controller and its core clock divider
`timescale 1ns/1ns
`default_nettype none
interface pmwd_doze_if;
  import pmwd_pkg::*;
  logic                  enable;
  logic [2:0]            ratio;
  logic                  tick;
  modport ctrl (output enable, output ratio, input tick);
  modport div  (input enable, input ratio, output tick);
endinterface
`default_nettype wire

/* File: design/pmwd_pkg.sv */
// constants, field layout and types of the power mode wake and doze controller
// Summary of operation
// - interrupt at priority level 0 never wakes the core from sleep
// - wake goes to handler if interrupt priority exceeds core priority, else resumes
// - every wake from sleep sets the was-asleep flag, bit 3
// - any reset wakes from sleep; non power-on sets was-asleep, power-on clears it
// - watchdog expiry in sleep wakes without reset, sets bits 4 and 3, resumes
// - idle entry halts the core and clears watchdog; system and peripheral clocks run
// - in idle the low-power rc oscillator runs if watchdog or clock monitor enabled
// - idle ends on enabled interrupt, reset or watchdog; core restarts at once
// - interrupt at priority level 0 never wakes the core from idle
// - every wake from idle sets the was-idle flag, bit 2
// - non power-on reset wakes from idle and sets was-idle; power-on clears it
// - watchdog expiry in idle wakes without reset, sets bits 4 and 2, resumes
// - wake from idle inserts no start-up or oscillator delay
// - interrupt during power-save instruction deferred until entry done, then wakes
// - doze slows only the core clock; system and peripheral clocks stay unchanged
// - doze active while doze-enable, bit 11 of clock divider register, is set
// - ratio field bits 14 to 12 selects eight ratios, 1:1 after reset
// - return-on-interrupt bit 15 resets to zero; when zero interrupts leave doze alone
// - interrupt in doze with return-on-interrupt set clears doze-enable by hardware
// - sleep entry shuts system oscillator and peripherals clocked from it
// - wake from sleep restarts the clock source active at sleep entry
// - enabled watchdog is cleared just before sleep entry
package pmwd_pkg;

  localparam int ADDR_W = 8;

  localparam logic [ADDR_W-1:0] ADDR_RESET_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CLOCK_DIV  = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG     = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = 8'h0C;

  localparam int RC_WATCHDOG_TIMEOUT_FLAG_BIT   = 4;
  localparam int RC_ASLEEP_BIT = 3;
  localparam int RC_IDLE_BIT   = 2;

  localparam int CD_ROI_BIT    = 15;
  localparam int CD_RATIO_LSB  = 12;
  localparam int CD_DOZE_BIT   = 11;
  localparam int CD_RCDIV_LSB  = 8;

  localparam logic [2:0] CD_RATIO_RESET = 3'h0;
  localparam logic [2:0] CD_RCDIV_RESET = 3'h3;

  localparam int CFG_WDT_EN_BIT  = 0;
  localparam int CFG_FAIL_SAFE_CLOCK_MONITOR_EN_BIT = 1;

  localparam int ST_MODE_LSB   = 0;
  localparam int ST_DOZE_BIT   = 2;

  localparam int OSC_SEL_W     = 2;
  localparam int PRIO_W        = 3;
  localparam int DOZE_CNT_W    = 7;

  typedef enum logic [1:0] {
    PMWD_RUN,
    PMWD_ENTER,
    PMWD_SLEEP,
    PMWD_IDLE
  } pmwd_mode_t;

endpackage

/* File: verif/pmwd_cpu_model.sv */
// core, interrupt controller and watchdog model facing the controller
`timescale 1ns/1ns
`default_nettype none
module pmwd_cpu_model
  import pmwd_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            woke,
  output logic                 psave_valid,
  output logic                 psave_idle,
  output logic [PRIO_W-1:0]    cpu_priority,
  output logic                 irq_pending,
  output logic                 irq_enabled,
  output logic [PRIO_W-1:0]    irq_priority,
  output logic                 wdt_expire,
  output logic                 soft_reset_req,
  output logic [OSC_SEL_W-1:0] osc_source
);
  logic waiting;

  initial begin
    psave_valid = 1'b0;
    psave_idle = 1'b0;
    cpu_priority = 3'h3;
    irq_pending = 1'b0;
    irq_enabled = 1'b0;
    irq_priority = 3'h0;
    wdt_expire = 1'b0;
    soft_reset_req = 1'b0;
    osc_source = 2'h0;
    waiting = 1'b0;
  end

  // core stays stopped from the power-save until a wake or reset pulse
  always @(posedge pclk) begin
    if (psave_valid === 1'b1)
      waiting <= 1'b1;
    else if (woke === 1'b1)
      waiting <= 1'b0;
  end

  task automatic psave(input logic idle);
    int n;
    n = 0;
    while (waiting === 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    psave_valid <= 1'b1;
    psave_idle <= idle;
    @(posedge pclk);
    psave_valid <= 1'b0;
    psave_idle <= ~idle;
  endtask

  task automatic irq(input logic p, input logic e, input logic [PRIO_W-1:0] pr);
    irq_pending <= p;
    irq_enabled <= e;
    irq_priority <= pr;
  endtask

  task automatic pulse(input logic wd);
    if (wd)
      wdt_expire <= 1'b1;
    else
      soft_reset_req <= 1'b1;
    @(posedge pclk);
    wdt_expire <= 1'b0;
    soft_reset_req <= 1'b0;
  endtask

  task automatic set_osc(input logic [OSC_SEL_W-1:0] o);
    osc_source <= o;
  endtask
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench of the power mode wake and doze controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pmwd_pkg::*;
  localparam logic [2:0] PULSE [4] = '{3'h4, 3'h2, 3'h2, 3'h1};
  logic                 pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic                 pwrite = 1'b0, pready, pslverr, psave_valid, psave_idle;
  logic                 irq_pending, irq_enabled, wdt_expire, soft_reset_req;
  logic                 cpu_clk_en, cpu_halted, periph_clk_en, sys_osc_en, low_power_rc_oscillator_en;
  logic                 wdt_clear, wake_resume, wake_isr, cpu_reset, doze_active;
  logic [ADDR_W-1:0]    paddr = '0;
  logic [3:0]           pstrb = 4'hF;
  logic [31:0]          pwdata = '0, prdata, rnd_s = 32'h760E3430;
  logic [PRIO_W-1:0]    cpu_priority, irq_priority;
  logic [OSC_SEL_W-1:0] osc_source, active_osc;
  logic [32:0]          rd_q[$];
  logic [2:0]           wk_q[$];
  int                   miscompares = 0, compares = 0;

  always #4 pclk = ~pclk;

  pmwd_ctrl dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psave_valid(psave_valid), .psave_idle(psave_idle),
    .cpu_priority(cpu_priority), .irq_pending(irq_pending), .irq_enabled(irq_enabled),
    .irq_priority(irq_priority), .wdt_expire(wdt_expire), .soft_reset_req(soft_reset_req),
    .osc_source(osc_source), .cpu_clk_en(cpu_clk_en), .cpu_halted(cpu_halted),
    .periph_clk_en(periph_clk_en), .sys_osc_en(sys_osc_en), .low_power_rc_oscillator_en(low_power_rc_oscillator_en),
    .active_osc(active_osc), .wdt_clear(wdt_clear), .wake_resume(wake_resume),
    .wake_isr(wake_isr), .cpu_reset(cpu_reset), .doze_active(doze_active)
  );

  pmwd_cpu_model cpu_u (
    .pclk(pclk), .woke(wake_resume | wake_isr | cpu_reset), .psave_valid(psave_valid),
    .psave_idle(psave_idle), .cpu_priority(cpu_priority), .irq_pending(irq_pending),
    .irq_enabled(irq_enabled), .irq_priority(irq_priority), .wdt_expire(wdt_expire),
    .soft_reset_req(soft_reset_req), .osc_source(osc_source)
  );

  function automatic logic [31:0] rnd();
    rnd_s = rnd_s ^ (rnd_s << 13);
    rnd_s = rnd_s ^ (rnd_s >> 17);
    rnd_s = rnd_s ^ (rnd_s << 5);
    return rnd_s;
  endfunction

  task automatic chk(input logic [32:0] g, input logic [32:0] e, input string m);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t ns: %s", $time, m);
    end
  endtask

  task automatic report_and_stop();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    // one idle edge so a following call never reassigns psel in this step
    @(posedge pclk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, rnd());
  endtask

  // result watcher: oldest note against each read or wake pulse
  always @(posedge pclk) begin
    if (psel && penable)
      chk(33'(pready), 33'h1, "no wait states");
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (rd_q.size() == 0)
        chk(33'h1, 33'h0, "unexpected read");
      else
        chk({pslverr, prdata}, rd_q.pop_front(), "read data");
    end
    if ((wake_resume | wake_isr | cpu_reset) === 1'b1) begin
      if (wk_q.size() == 0)
        chk(33'h1, 33'h0, "unexpected wake");
      else
        chk(33'({wake_isr, wake_resume, cpu_reset}), 33'(wk_q.pop_front()), "wake kind");
    end
  end

  task automatic wait_wake(input int lim, input string m);
    int n;
    n = 0;
    while ((wake_resume | wake_isr | cpu_reset) !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(33'(n < lim), 33'h1, m);
  endtask

  task automatic mode_case(input logic idle, input logic [1:0] k);
    logic [31:0]          r;
    logic                 we;
    logic [OSC_SEL_W-1:0] o;
    int                   nclr;
    r = rnd();
    we = (k == 2'h2) | r[0];
    o = r[9:8];
    nclr = 0;
    apb(1'b1, ADDR_RESET_CTRL, 32'h0);
    apb(1'b1, ADDR_CONFIG, {30'h0, r[1], we});
    cpu_u.set_osc(o);
    cpu_u.irq(1'b1, k[0], k[0] ? 3'h0 : 3'h6);
    cpu_u.psave(idle);
    cpu_u.set_osc(~o);
    repeat (4) begin
      @(posedge pclk);
      nclr += int'(wdt_clear === 1'b1);
    end
    chk(33'(nclr), 33'(idle | we), "watchdog clear");
    chk(33'({sys_osc_en, periph_clk_en, cpu_halted, low_power_rc_oscillator_en}),
        33'({idle, idle, 1'b1, we | (r[1] & idle)}), "clocks");
    rd(ADDR_STATUS, idle ? 33'h3 : 33'h2);
    wk_q.push_back(PULSE[k]);
    if (k[1])
      cpu_u.pulse(~k[0]);
    else
      cpu_u.irq(1'b1, 1'b1, k[0] ? 3'h3 : 3'h5);
    wait_wake(3, "wake delay");
    cpu_u.irq(1'b0, 1'b0, 3'h0);
    chk(33'(active_osc), 33'(o), "clock source");
    rd(ADDR_RESET_CTRL, 33'((idle ? 5'h04 : 5'h08) | (k == 2'h2 ? 5'h10 : 5'h00)));
  endtask

  initial begin
    repeat (25000) @(posedge pclk);
    miscompares++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_RESET_CTRL, 33'h0);
    pstrb <= 4'h1;
    apb(1'b1, ADDR_CLOCK_DIV, 32'h0000F800);
    pstrb <= 4'hF;
    rd(ADDR_CLOCK_DIV, 33'h300);
    rd(ADDR_CONFIG, 33'h0);
    apb(1'b1, ADDR_STATUS, 32'hFFFF);
    rd(ADDR_STATUS, 33'h0);
    rd(8'h10, 33'h100000000);
    done("registers");
    for (int i = 0; i < 8; i++) mode_case(i[2], i[1:0]);
    done("wake");
    apb(1'b1, ADDR_RESET_CTRL, 32'h0);
    cpu_u.irq(1'b1, 1'b1, 3'h5);
    wk_q.push_back(3'h4);
    cpu_u.psave(1'b0);
    wait_wake(6, "deferred wake");
    cpu_u.irq(1'b0, 1'b0, 3'h0);
    rd(ADDR_RESET_CTRL, 33'h08);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_RESET_CTRL, 33'h0);
    done("deferred and power-on");
    for (int n = 0; n < 8; n++) begin
      logic [31:0] v;
      int          t;
      int          p;
      v = {16'h0, 1'b0, 3'(n), 1'b1, 3'h3, 8'h00};
      t = 0;
      p = 0;
      apb(1'b1, ADDR_CLOCK_DIV, v);
      rd(ADDR_CLOCK_DIV, 33'(v));
      rd(ADDR_STATUS, 33'h4);
      repeat (256) begin
        @(posedge pclk);
        t += int'(cpu_clk_en === 1'b1);
        p += int'(periph_clk_en === 1'b1);
      end
      chk(33'(t), 33'(256 >> n), "doze ratio");
      chk(33'(p), 33'h100, "peripheral clock");
    end
    cpu_u.irq(1'b1, 1'b1, 3'h5);
    repeat (3) @(posedge pclk);
    chk(33'(doze_active), 33'h1, "doze kept");
    cpu_u.irq(1'b0, 1'b0, 3'h0);
    apb(1'b1, ADDR_CLOCK_DIV, 32'h0000F800);
    cpu_u.irq(1'b1, 1'b1, 3'h5);
    repeat (2) @(posedge pclk);
    chk(33'(doze_active), 33'h0, "doze return");
    cpu_u.irq(1'b0, 1'b0, 3'h0);
    rd(ADDR_CLOCK_DIV, 33'h0000F000);
    @(posedge pclk);
    chk(33'(rd_q.size() + wk_q.size()), 33'h0, "results outstanding");
    done("doze");
    report_and_stop();
  end
endmodule
`default_nettype wire
